// ===== shared/aci_pkg.sv
// Package for the ancillary caption and format-code inserter.
// Assumes one 250 MHz clock and a plain register port.
package aci_pkg;

	localparam int CLK_MHZ = 250;
	localparam logic [5:0] LINE_MIN = 6'h09;
	localparam logic [5:0] LINE_MAX = 6'h29;
	localparam logic [5:0] LINE_DEF = 6'h0A;
	localparam logic [3:0] TOPSUP_MAX = 4'hA;
	localparam logic [15:0] CAP_ID = 16'h9669;

	// Register indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_LINE = 4'h1;
	localparam logic [3:0] REG_RESTORE = 4'h2;
	localparam logic [3:0] REG_CODE = 4'h3;
	localparam logic [3:0] REG_ARC = 4'h4;
	localparam logic [3:0] REG_OVL = 4'h5;
	localparam logic [3:0] REG_CAP = 4'h6;
	localparam logic [3:0] REG_STAT = 4'h7;
	localparam logic [3:0] REG_LIMITS = 4'h8;

	// Restore handshake codes
	localparam logic [1:0] RST_REQ = 2'h1;
	localparam logic [1:0] RST_YES = 2'h2;
	localparam logic [1:0] RST_NO = 2'h3;

	// Control bit positions
	localparam int CTRL_FMT_EN = 0;
	localparam int CTRL_REASPECT = 1;
	localparam int CTRL_SCALER = 2;
	localparam int CTRL_CAP_EN = 3;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [3:0] CODE_RESET = 4'h0;

	typedef enum logic [2:0] {
		REJ_NONE = 3'b000,
		REJ_NO_ID = 3'b001,
		REJ_RATE = 3'b010,
		REJ_NO_DATA = 3'b011,
		REJ_INACTIVE = 3'b100
	} aci_rej_e;

	typedef struct packed {
		logic [15:0] ident;
		logic [3:0] rate;
		logic data_present;
		logic svc_active;
	} aci_cap_hdr_s;

	typedef struct packed {
		logic valid;
		logic sof;
		logic [9:0] data;
	} aci_word_s;

	typedef struct packed {
		logic [9:0] y;
		logic [9:0] cb;
		logic [9:0] cr;
	} aci_color_s;

endpackage

// ===== core/aci_anc_packer.sv
// Serialises one ancillary packet with a 9-bit checksum.
// Assumes start arrives only while idle.
`timescale 1ns/1ns
module aci_anc_packer (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic start_i,
	input wire logic [7:0] did_i,
	input wire logic [7:0] sdid_i,
	input wire logic [7:0] payload_i,
	output aci_pkg::aci_word_s word_o,
	output logic busy_o
);
	import aci_pkg::*;

	typedef enum logic [2:0] {
		PK_IDLE = 3'b000,
		PK_HDR = 3'b001,
		PK_DID = 3'b010,
		PK_SDID = 3'b011,
		PK_DC = 3'b100,
		PK_UDW = 3'b101,
		PK_CS = 3'b110
	} aci_pk_e;

	aci_pk_e st_q;
	logic [1:0] hcnt_q;
	logic [8:0] sum_q;
	aci_word_s word_q;

	// Parity on bit 8, inverse on bit 9
	function automatic logic [9:0] par10(input logic [7:0] v);
		par10 = {~(^v), ^v, v};
	endfunction

	wire logic [9:0] did_w = par10(did_i);
	wire logic [9:0] sdid_w = par10(sdid_i);
	wire logic [9:0] dc_w = par10(8'h01);
	wire logic [9:0] udw_w = par10(payload_i);
	wire logic [9:0] cs_w = {~sum_q[8], sum_q};

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= PK_IDLE;
			hcnt_q <= 2'h0;
			sum_q <= 9'h000;
			word_q <= '0;
		end else begin
			word_q.valid <= st_q != PK_IDLE;
			word_q.sof <= st_q == PK_HDR && hcnt_q == 2'h0;
			unique case (st_q)
				PK_IDLE: begin
					sum_q <= 9'h000;
					hcnt_q <= 2'h0;
					if (start_i) begin
						st_q <= PK_HDR;
					end
				end
				PK_HDR: begin
					word_q.data <= (hcnt_q == 2'h0) ? 10'h000 : 10'h3FF;
					hcnt_q <= hcnt_q + 2'h1;
					if (hcnt_q == 2'h2) begin
						word_q.data <= 10'h3FF;
						st_q <= PK_DID;
					end
				end
				PK_DID: begin
					word_q.data <= did_w;
					sum_q <= sum_q + did_w[8:0];
					st_q <= PK_SDID;
				end
				PK_SDID: begin
					word_q.data <= sdid_w;
					sum_q <= sum_q + sdid_w[8:0];
					st_q <= PK_DC;
				end
				PK_DC: begin
					word_q.data <= dc_w;
					sum_q <= sum_q + dc_w[8:0];
					st_q <= PK_UDW;
				end
				PK_UDW: begin
					word_q.data <= udw_w;
					sum_q <= sum_q + udw_w[8:0];
					st_q <= PK_CS;
				end
				PK_CS: begin
					word_q.data <= cs_w;
					st_q <= PK_IDLE;
				end
				default: st_q <= PK_IDLE;
			endcase
		end
	end

	assign word_o = word_q;
	assign busy_o = st_q != PK_IDLE;
endmodule

// ===== core/aci_inserter.sv
// Ancillary inserter: format code packets, overlay outlines, caption checks.
// Assumes synchronous video timing inputs and a single-cycle register port.
`timescale 1ns/1ns
module aci_inserter #(
	parameter int NUM_CODES = 16,
	parameter int NUM_COLORS = 4
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [5:0] line_num_i,
	input wire logic line_start_i,
	input wire logic [5:0] fmt_line_lo_i,
	input wire logic [5:0] fmt_line_hi_i,
	input wire logic in_hd_i,
	input wire logic out_hd_i,
	input wire logic [10:0] pix_x_i,
	input wire logic [10:0] pix_y_i,
	input wire aci_pkg::aci_color_s video_i,
	input wire logic [11:0] act_box_i,
	input wire logic [11:0] title_box_i,
	input wire logic hdr_valid_i,
	input wire aci_pkg::aci_cap_hdr_s hdr_i,
	input wire logic [5:0] hdr_line_i,
	input wire logic [3:0] rx_code_i,
	input wire logic rx_code_valid_i,
	output aci_pkg::aci_color_s video_o,
	output aci_pkg::aci_word_s anc_o,
	output logic cap_fwd_o,
	output logic cap_strip_o,
	output logic cap_legacy_only_o,
	output logic [5:0] cap_line_o,
	output logic [3:0] topsup_o,
	output logic [7:0] arc_sel_o
);
	import aci_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [31:0] ctrl_q;
	logic [5:0] line_sel_q;
	logic [3:0] code_q;
	logic [7:0] arc_tab_q [NUM_CODES];
	logic [1:0] ovl_en_q;
	logic [1:0] act_col_q;
	logic [1:0] title_col_q;
	logic [3:0] topsup_q;
	logic restore_pend_q;
	logic [31:0] rdata_q;

	function automatic logic sel(input logic [3:0] a, input logic [3:0] idx);
		sel = a == idx;
	endfunction

	wire logic wr_ctrl = reg_wr_i && sel(reg_addr_i, REG_CTRL);
	wire logic wr_line = reg_wr_i && sel(reg_addr_i, REG_LINE);
	wire logic wr_rst = reg_wr_i && sel(reg_addr_i, REG_RESTORE);
	wire logic wr_code = reg_wr_i && sel(reg_addr_i, REG_CODE);
	wire logic wr_arc = reg_wr_i && sel(reg_addr_i, REG_ARC);
	wire logic wr_ovl = reg_wr_i && sel(reg_addr_i, REG_OVL);
	wire logic wr_cap = reg_wr_i && sel(reg_addr_i, REG_CAP);
	wire logic [1:0] rst_cmd = reg_wdata_i[1:0];
	wire logic do_restore = wr_rst && restore_pend_q && rst_cmd == RST_YES;
	wire logic [5:0] line_wr_w = reg_wdata_i[5:0];
	wire logic line_ok = line_wr_w >= LINE_MIN && line_wr_w <= LINE_MAX;
	wire logic [3:0] tsup_w = reg_wdata_i[3:0];
	wire logic [3:0] arc_idx = reg_wdata_i[11:8];

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			restore_pend_q <= 1'b0;
		end else if (wr_rst) begin
			restore_pend_q <= rst_cmd == RST_REQ;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_q <= CTRL_RESET;
			line_sel_q <= LINE_DEF;
			code_q <= CODE_RESET;
		end else if (do_restore) begin
			ctrl_q <= CTRL_RESET;
			line_sel_q <= LINE_DEF;
			code_q <= CODE_RESET;
		end else begin
			if (wr_ctrl) ctrl_q <= reg_wdata_i;
			if (wr_line && line_ok) line_sel_q <= line_wr_w;
			if (wr_code) code_q <= reg_wdata_i[3:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CODES; gi++) begin : g_arc
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					arc_tab_q[gi] <= 8'h00;
				end else if (do_restore) begin
					arc_tab_q[gi] <= 8'h00;
				end else if (wr_arc && arc_idx == 4'(gi)) begin
					arc_tab_q[gi] <= reg_wdata_i[7:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ovl_en_q <= 2'b00;
			act_col_q <= 2'h0;
			title_col_q <= 2'h0;
		end else if (wr_ovl) begin
			ovl_en_q <= reg_wdata_i[1:0];
			act_col_q <= reg_wdata_i[5:4];
			title_col_q <= reg_wdata_i[9:8];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			topsup_q <= 4'h0;
		end else if (wr_cap) begin
			topsup_q <= tsup_w > TOPSUP_MAX ? TOPSUP_MAX : tsup_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Format code packet insertion

	// Neighbour data on the line is not checked; software keeps it free
	wire logic [5:0] line_lo_w = fmt_line_lo_i > line_sel_q ? fmt_line_lo_i : line_sel_q;
	wire logic [5:0] line_use_w = line_lo_w > fmt_line_hi_i ? fmt_line_hi_i : line_lo_w;
	wire logic fmt_en = ctrl_q[CTRL_FMT_EN];
	wire logic pk_start = fmt_en && line_start_i && line_num_i == line_use_w;
	wire logic pk_busy;
	aci_word_s anc_w;

	aci_anc_packer u_packer (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(pk_start && !pk_busy),
		.did_i(8'h41),
		.sdid_i(8'h05),
		.payload_i({1'b0, code_q, 3'b000}),
		.word_o(anc_w),
		.busy_o(pk_busy)
	);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			anc_o <= '0;
		end else begin
			anc_o <= anc_w;
		end
	end

	// Aspect choice: received code when re-aspecting and rx_code_valid_i is set, else attached code
	wire logic use_rx = ctrl_q[CTRL_REASPECT] && rx_code_valid_i;
	wire logic [3:0] arc_code = use_rx ? rx_code_i : code_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			arc_sel_o <= 8'h00;
			topsup_o <= 4'h0;
		end else begin
			arc_sel_o <= arc_tab_q[arc_code];
			topsup_o <= topsup_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Overlay outlines

	function automatic logic on_box(input logic [10:0] x, input logic [10:0] y,
		input logic [11:0] b);
		logic [10:0] lo;
		logic [10:0] hx;
		logic [10:0] hy;
		lo = {5'h00, b[5:0]};
		hx = 11'h780 - lo;
		hy = 11'h438 - lo;
		on_box = ((x == lo || x == hx) && y >= lo && y <= hy) ||
			((y == lo || y == hy) && x >= lo && x <= hx);
	endfunction

	function automatic aci_color_s pal(input logic [1:0] c);
		unique case (c)
			2'h0: pal = {10'h3AC, 10'h200, 10'h200};
			2'h1: pal = {10'h040, 10'h200, 10'h200};
			2'h2: pal = {10'h2A0, 10'h090, 10'h3C0};
			2'h3: pal = {10'h250, 10'h3C0, 10'h060};
		endcase
	endfunction

	wire logic hit_act = ovl_en_q[0] && on_box(pix_x_i, pix_y_i, act_box_i);
	wire logic hit_title = ovl_en_q[1] && on_box(pix_x_i, pix_y_i, title_box_i);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			video_o <= '0;
		end else if (hit_title) begin
			video_o <= pal(title_col_q);
		end else if (hit_act) begin
			video_o <= pal(act_col_q);
		end else begin
			video_o <= video_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Caption header checks and status

	wire logic cap_en = ctrl_q[CTRL_CAP_EN];
	wire logic rate_film = hdr_i.rate == 4'h1 || hdr_i.rate == 4'h2;
	aci_rej_e rej_w;
	assign rej_w = hdr_i.ident != CAP_ID ? REJ_NO_ID :
		rate_film ? REJ_RATE :
		!hdr_i.data_present ? REJ_NO_DATA :
		!hdr_i.svc_active ? REJ_INACTIVE : REJ_NONE;
	// Inactive service is only reported; data still passes
	wire logic hdr_ok = rej_w == REJ_NONE || rej_w == REJ_INACTIVE;

	aci_rej_e rej_q;
	logic present_q;
	logic [5:0] in_line_q;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rej_q <= REJ_NONE;
			present_q <= 1'b0;
			in_line_q <= 6'h00;
			cap_fwd_o <= 1'b0;
		end else begin
			// Caption off does not drop packets; only the strip path removes them
			cap_fwd_o <= hdr_valid_i && hdr_ok;
			if (!cap_en) begin
				present_q <= 1'b0;
			end else if (hdr_valid_i) begin
				rej_q <= rej_w;
				present_q <= hdr_ok;
				if (hdr_ok) in_line_q <= hdr_line_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cap_strip_o <= 1'b0;
			cap_legacy_only_o <= 1'b0;
			cap_line_o <= LINE_DEF;
		end else begin
			cap_strip_o <= !cap_en && ctrl_q[CTRL_SCALER];
			// HD to SD lands on line 21; SD to HD keeps only the older kind
			cap_legacy_only_o <= !in_hd_i && out_hd_i;
			cap_line_o <= out_hd_i ? LINE_DEF : 6'h15;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port

	wire logic [31:0] stat_w = {16'h0000, 2'b00, in_line_q, 4'h0, present_q, rej_q};
	logic [31:0] rmux;
	always_comb begin
		unique case (reg_addr_i)
			REG_CTRL: rmux = ctrl_q;
			REG_LINE: rmux = {26'h000_0000, line_sel_q};
			REG_RESTORE: rmux = {31'h0000_0000, restore_pend_q};
			REG_CODE: rmux = {28'h000_0000, code_q};
			REG_OVL: rmux = {22'h00_0000, title_col_q, 2'b00, act_col_q, 2'b00, ovl_en_q};
			REG_CAP: rmux = {28'h000_0000, topsup_q};
			REG_STAT: rmux = stat_w;
			REG_LIMITS: rmux = {16'h0000, 2'b00, line_use_w, 2'b00, fmt_line_hi_i};
			default: rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= reg_rd_i ? rmux : 32'h0000_0000;
		end
	end

	assign reg_rdata_o = rdata_q;
endmodule

// ===== test/aci_inserter_monitor.sv
// Port checker for the inserter.
// Bound to aci_inserter from the testbench top file.
`timescale 1ns/1ns
module aci_inserter_monitor
	import aci_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic hdr_valid_i,
	input wire aci_pkg::aci_cap_hdr_s hdr_i,
	input wire logic cap_fwd_o,
	input wire logic [5:0] cap_line_o,
	input wire logic [3:0] topsup_o,
	input wire aci_pkg::aci_word_s anc_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire logic film_rate = hdr_i.rate == 4'h1 || hdr_i.rate == 4'h2;
	wire logic hdr_ok = hdr_i.ident == CAP_ID && !film_rate && hdr_i.data_present;

	a_rd_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
		else $error("read data outside the read answer cycle");
	a_hdr_pass_fwd: assert property (hdr_valid_i && hdr_ok |=> cap_fwd_o)
		else $error("good caption header not forwarded");
	a_id_reject: assert property (hdr_valid_i && hdr_i.ident != CAP_ID |=> !cap_fwd_o)
		else $error("unidentified header forwarded");
	a_rate_reject: assert property (hdr_valid_i && film_rate |=> !cap_fwd_o)
		else $error("film rate header forwarded");
	a_nodata_reject: assert property (hdr_valid_i && !hdr_i.data_present |=> !cap_fwd_o)
		else $error("empty header forwarded");
	a_fwd_has_cause: assert property (cap_fwd_o |-> $past(hdr_valid_i) && $past(hdr_ok))
		else $error("forward pulse without accepted header");
	a_topsup_bound: assert property (topsup_o <= TOPSUP_MAX)
		else $error("top line count above ten");
	a_anc_preamble: assert property (anc_o.valid && anc_o.sof |-> anc_o.data == 10'h000
		##1 anc_o.valid && anc_o.data == 10'h3FF ##1 anc_o.valid && anc_o.data == 10'h3FF)
		else $error("packet flag sequence wrong");
	a_cap_line_rng: assert property (cap_line_o >= LINE_MIN && cap_line_o <= LINE_MAX)
		else $error("caption line outside ancillary range");
endmodule

// ===== test/aci_video_far.sv
// Far side model: line timing source and downstream packet receiver.
// Assumes packet words arrive back to back after the start flag.
`timescale 1ns/1ns
module aci_video_far
	import aci_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire aci_pkg::aci_word_s anc_i,
	output logic [5:0] line_num_o,
	output logic line_start_o,
	output logic [7:0] pkt_count_o,
	output logic [7:0] pkt_bad_o,
	output logic [7:0] udw_o,
	output logic [5:0] pkt_line_o
);
	logic [9:0] w [8];
	logic [3:0] pix_q;
	logic [3:0] idx_q;
	logic [8:0] sum;
	assign line_start_o = pix_q == 4'h0;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pix_q <= 4'h0;
			idx_q <= 4'h8;
			line_num_o <= 6'h01;
			pkt_count_o <= 8'h00;
			pkt_bad_o <= 8'h00;
			udw_o <= 8'h00;
			pkt_line_o <= 6'h00;
		end else begin
			pix_q <= pix_q + 4'h1;
			// Short 16-cycle lines keep a 45-line frame quick
			if (pix_q == 4'hF)
				line_num_o <= line_num_o == 6'h2D ? 6'h01 : line_num_o + 6'h01;
			if (anc_i.valid && (anc_i.sof || idx_q < 4'h8)) begin
				if (anc_i.sof)
					pkt_line_o <= line_num_o;
				w[anc_i.sof ? 4'h0 : idx_q] = anc_i.data;
				idx_q <= anc_i.sof ? 4'h1 : idx_q + 4'h1;
				if (idx_q == 4'h7 && !anc_i.sof) begin
					sum = w[3][8:0] + w[4][8:0] + w[5][8:0] + w[6][8:0];
					pkt_count_o <= pkt_count_o + 8'h01;
					udw_o <= w[6][7:0];
					if (w[7][8:0] != sum || w[7][9] == w[7][8] || w[3][7:0] != 8'h41
						|| w[4][7:0] != 8'h05 || w[5][7:0] != 8'h01)
						pkt_bad_o <= pkt_bad_o + 8'h01;
				end
			end
		end
	end
endmodule

// ===== test/aci_inserter_tb_top.sv
// Self-checking bench for the inserter with integer reference values.
// Assumes the far-side model and the monitor are compiled before it.
`timescale 1ns/1ns
module aci_inserter_tb_top;
	import aci_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic in_hd_i = 1'b1;
	logic out_hd_i = 1'b1;
	logic hdr_valid_i = 1'b0;
	logic rx_code_valid_i = 1'b0;
	logic [5:0] hdr_line_i = 6'h00;
	logic [5:0] fmt_line_lo_i = 6'h09;
	logic [5:0] fmt_line_hi_i = 6'h29;
	logic [10:0] pix_x_i = 11'h000;
	logic [10:0] pix_y_i = 11'h21C;
	logic [11:0] act_box_i = 12'h028;
	logic [11:0] title_box_i = 12'h030;
	logic [3:0] rx_code_i = 4'h0;
	aci_color_s video_i = '0;
	aci_cap_hdr_s hdr_i = '0;
	logic [31:0] reg_rdata_o;
	logic [5:0] line_num_i, cap_line_o, pkt_line;
	logic line_start_i, cap_fwd_o, cap_strip_o, cap_legacy_only_o;
	logic [3:0] topsup_o;
	logic [7:0] arc_sel_o, pkt_count, pkt_bad, udw;
	aci_color_s video_o;
	aci_word_s anc_o;
	logic [31:0] seed = 32'h0000_0056;
	logic [31:0] d;
	int bad_count = 0;
	int total_checks = 0;
	int line_m, used, code_m, arc_m[16];
	int lines[5] = '{9, 8, 41, 42, 30};
	// Header, then reason code and forward flag
	logic [25:0] hdrs[6] = '{{CAP_ID, 4'h4, 2'b11, 3'h0, 1'b1}, {16'h1234, 4'h4, 2'b11, 3'h1, 1'b0},
		{CAP_ID, 4'h1, 2'b11, 3'h2, 1'b0}, {CAP_ID, 4'h2, 2'b11, 3'h2, 1'b0},
		{CAP_ID, 4'h4, 2'b01, 3'h3, 1'b0}, {CAP_ID, 4'h4, 2'b10, 3'h4, 1'b1}};

	always #2 clk_i = ~clk_i;

	aci_inserter dut (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .line_num_i, .line_start_i, .fmt_line_lo_i, .fmt_line_hi_i, .in_hd_i,
		.out_hd_i, .pix_x_i, .pix_y_i, .video_i, .act_box_i, .title_box_i, .hdr_valid_i, .hdr_i,
		.hdr_line_i, .rx_code_i, .rx_code_valid_i, .video_o, .anc_o, .cap_fwd_o, .cap_strip_o,
		.cap_legacy_only_o, .cap_line_o, .topsup_o, .arc_sel_o);
	aci_video_far far (.clk_i, .reset_n_i, .anc_i(anc_o), .line_num_o(line_num_i),
		.line_start_o(line_start_i), .pkt_count_o(pkt_count), .pkt_bad_o(pkt_bad),
		.udw_o(udw), .pkt_line_o(pkt_line));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task automatic wait_pkt();
		logic [7:0] c;
		c = pkt_count;
		for (int n = 0; n < 2000 && pkt_count == c; n++)
			@(posedge clk_i);
		if (pkt_count == c) begin
			chk("packet arrival", 1, 0);
			test_done();
		end
	endtask
	task automatic px(input logic [10:0] x, input logic hit, input string n);
		aci_color_s v;
		d = rnd();
		v = d[29:0];
		@(posedge clk_i);
		pix_x_i <= x;
		video_i <= v;
		@(posedge clk_i);
		#1 chk(n, hit, video_o !== v);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int v;
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(REG_CTRL);
		chk("ctrl reset", CTRL_RESET, d);
		foreach (lines[i]) begin
			wr(REG_LINE, lines[i]);
			if (lines[i] >= 9 && lines[i] <= 41)
				line_m = lines[i];
			rd(REG_LINE);
			chk("line select", line_m, d);
		end
		@(posedge clk_i);
		fmt_line_lo_i <= 6'h0C;
		fmt_line_hi_i <= 6'h14;
		code_m = rnd() % 15 + 1;
		wr(REG_CODE, code_m);
		wr(REG_CTRL, 32'h0000_0001);
		for (int k = 0; k < 2; k++) begin
			used = line_m < 12 ? 12 : line_m > 20 ? 20 : line_m;
			rd(REG_LIMITS);
			chk("used line", used * 256 + 20, d);
			wait_pkt();
			wait_pkt();
			chk("packet line", used, pkt_line);
			chk("packet code", code_m * 8, udw);
			chk("packet format", 0, pkt_bad);
			wr(REG_LINE, 9);
			line_m = 9;
		end
		wr(REG_RESTORE, RST_YES);
		rd(REG_CODE);
		chk("code without request", code_m, d);
		wr(REG_RESTORE, RST_REQ);
		wr(REG_RESTORE, RST_NO);
		rd(REG_CODE);
		chk("code after refusal", code_m, d);
		wr(REG_RESTORE, RST_REQ);
		wr(REG_RESTORE, RST_YES);
		rd(REG_CODE);
		chk("code after restore", CODE_RESET, d);
		rd(REG_CTRL);
		chk("ctrl after restore", CTRL_RESET, d);
		for (int k = 2; k < 16; k += 7) begin
			arc_m[k] = rnd() % 256;
			wr(REG_ARC, k * 256 + arc_m[k]);
		end
		wr(REG_CTRL, 32'h0000_0003);
		rx_code_valid_i <= 1'b1;
		// Attached code differs from the received one, so the source is visible
		for (int k = 2; k < 16; k += 7) begin
			wr(REG_CODE, 11 - k);
			rx_code_i <= k[3:0];
			repeat (3) @(posedge clk_i);
			chk("aspect select", arc_m[k], arc_sel_o);
		end
		rx_code_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("attached aspect", arc_m[2], arc_sel_o);
		for (int k = 0; k < 4; k++) begin
			wr(REG_OVL, k * 273);
			px(11'h028, k[0], "action outline");
			px(11'h030, k[1], "title outline");
			px(11'h1F4, 1'b0, "picture interior");
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_i);
			in_hd_i <= k[1];
			out_hd_i <= k[0];
			wr(REG_CTRL, 32'h0000_0008);
			repeat (2) @(posedge clk_i);
			chk("legacy only", !k[1] && k[0], cap_legacy_only_o);
			chk("caption line", k[0] ? LINE_DEF : 21, cap_line_o);
		end
		for (int k = 0; k < 4; k++) begin
			wr(REG_CTRL, (k & 1) * 8 + (k & 2) * 2);
			repeat (2) @(posedge clk_i);
			chk("strip", !k[0] && k[1], cap_strip_o);
		end
		wr(REG_CTRL, 32'h0000_0008);
		foreach (hdrs[i]) begin
			v = 9 + rnd() % 33;
			@(posedge clk_i);
			hdr_i <= hdrs[i][25:4];
			hdr_line_i <= v[5:0];
			hdr_valid_i <= 1'b1;
			@(posedge clk_i);
			hdr_valid_i <= 1'b0;
			#1 chk("forward", hdrs[i][0], cap_fwd_o);
			repeat (4) @(posedge clk_i);
			rd(REG_STAT);
			chk("reason", hdrs[i][3:1], d[2:0]);
			if (hdrs[i][0])
				chk("presence", v * 256 + 8 + hdrs[i][3:1], d[13:0]);
		end
		wr(REG_CTRL, 32'h0000_0000);
		repeat (2) @(posedge clk_i);
		rd(REG_STAT);
		chk("absent when off", 0, d[3]);
		for (int k = 0; k < 5; k++) begin
			v = k == 0 ? 15 : rnd() % 16;
			wr(REG_CAP, v);
			repeat (2) @(posedge clk_i);
			chk("top lines", v > 10 ? 10 : v, topsup_o);
		end
		rd(4'hF);
		chk("unmapped read", 0, d);
		test_done();
	end
endmodule

bind aci_inserter aci_inserter_monitor mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .hdr_valid_i(hdr_valid_i), .hdr_i(hdr_i),
	.cap_fwd_o(cap_fwd_o), .cap_line_o(cap_line_o), .topsup_o(topsup_o), .anc_o(anc_o));
